// ---- common/vdec_cfg_pkg.sv ----
// package for the decoder tracking configuration bank
// assumes byte-wide register port with printed byte offsets as addresses
package vdec_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BURST_TH    = 8'h08;
  localparam logic [7:0] ADDR_COMB        = 8'h09;
  localparam logic [7:0] ADDR_PALSW       = 8'h0C;
  localparam logic [7:0] ADDR_STD_STS     = 8'h10;
  localparam logic [7:0] ADDR_LOCK_STS    = 8'h11;
  localparam logic [7:0] ADDR_LOCK_LMT    = 8'h12;
  localparam logic [7:0] ADDR_CFG_A       = 8'h13;
  localparam logic [7:0] ADDR_CFG_B       = 8'h14;
  localparam logic [7:0] ADDR_OFS_CTL     = 8'h15;
  localparam logic [7:0] ADDR_CTI         = 8'h17;
  localparam logic [7:0] ADDR_LVL_CTL     = 8'h18;
  localparam logic [7:0] ADDR_GAIN        = 8'h20;
  localparam logic [7:0] ADDR_BOTTOM_LO   = 8'h21;
  localparam logic [7:0] ADDR_PEDESTAL_LO = 8'h22;
  localparam logic [7:0] ADDR_OFS_B0      = 8'h23;
  localparam logic [7:0] ADDR_OFS_B1      = 8'h24;
  localparam logic [7:0] ADDR_OFS_TOP     = 8'h25;
  localparam logic [7:0] ADDR_LVL_HI      = 8'h26;
  localparam logic [7:0] ADDR_PANEL       = 8'h29;
  // extra control register for bits that live outside this bank
  localparam logic [7:0] ADDR_AUX         = 8'h3C;

  // reset values
  localparam logic [7:0] RST_BURST_TH = 8'h20;
  localparam logic [7:0] RST_COMB     = 8'h00;
  localparam logic [7:0] RST_PALSW    = 8'h00;
  localparam logic [7:0] RST_LOCK_LMT = 8'h3F;
  localparam logic [7:0] RST_CFG_A    = 8'h69;
  localparam logic [7:0] RST_CFG_B    = 8'h05;
  localparam logic [7:0] RST_OFS_CTL  = 8'h0C;
  localparam logic [7:0] RST_CTI      = 8'h0A;
  localparam logic [7:0] RST_LVL_CTL  = 8'h00;
  localparam logic [7:0] RST_PANEL    = 8'h00;
  localparam logic [7:0] RST_AUX      = 8'h08;
  localparam logic [7:0] RST_SYNC_TH  = 8'h30;

  // field positions
  localparam int B_VCOMB_DIS   = 0;
  localparam int B_NOTCH_SEL   = 1;
  localparam int B_LUMA_FORCE  = 4;
  localparam int B_PALSW       = 0;
  localparam int B_SHARP_LO    = 6;
  localparam int B_WIN_LO      = 4;
  localparam int B_GAIN_FREEZE = 5;
  localparam int B_AUTO_DR     = 6;
  localparam int B_FORCE_DR    = 7;
  localparam int B_STOP_OPT    = 0;
  localparam int B_HOLD_OPT    = 1;
  localparam int B_EDGE_SEL    = 2;
  localparam int B_SETTLE_LO   = 5;
  localparam int B_FIXED_OFS   = 0;
  localparam int B_FIXED_SYNC  = 1;
  localparam int B_FRAC_TRACK  = 2;
  localparam int B_PORCH_TRK   = 7;
  localparam int B_THR_AUTO    = 0;
  localparam int B_BOTTOM_TRK  = 1;
  localparam int B_THR_FIXED   = 2;
  localparam int B_CHROMA_AGC  = 3;
  localparam int B_PROG_AUTO   = 4;
  localparam int B_CKILL_OFF   = 6;
  localparam int B_THR_KEEP    = 7;
  localparam int B_NTSC_PANEL  = 0;
  localparam int B_PAL_PANEL   = 1;
  localparam int B_MONO_CHROMA = 7;
  localparam int B_PANEL_EN    = 3;
  localparam int B_QUICK_SW    = 5;
  localparam int B_LL_AUTO     = 0;
  localparam int B_LOCK_FLAG   = 7;
  localparam int B_PROG_FLAG   = 0;

  // constants
  localparam logic [7:0] NEUTRAL_CHROMA = 8'h80;
  localparam logic [4:0] FRAMES_8       = 5'h08;
  localparam logic [4:0] FRAMES_16      = 5'h10;
  localparam logic [5:0] PPM_PER_STEP   = 6'h08;

endpackage : vdec_cfg_pkg

// ---- src/vdec_tracking_cfg.sv ----
// configuration and status bank of one composite decoder channel
// assumes pixel path, status and level inputs synchronous to clk
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

module vdec_tracking_cfg #(
  parameter int OFS_W = 21                 // clock offset width
) (
  input  wire logic              clk,              // decoder clock
  input  wire logic              rst_n,            // sync reset, active low
  input  wire logic [7:0]        addr,             // register address
  input  wire logic [7:0]        wdata,            // write data
  input  wire logic              wr,               // write strobe
  input  wire logic              rd,               // read strobe
  input  wire logic [7:0]        cb_in,            // decoded cb
  input  wire logic [7:0]        cr_in,            // decoded cr
  input  wire logic              frame_end,        // one pulse per decoded frame
  input  wire logic              decode_start,     // pulse at decode start
  input  wire logic              video_present,    // signal detected
  input  wire logic              burst_443,        // 4.43 subcarrier detected
  input  wire logic [7:0]        std_flags,        // detected standard flags
  input  wire logic              progressive_in,   // progressive detected
  input  wire logic [OFS_W-1:0]  ofs_measured,     // measured clock offset, ppm
  input  wire logic [7:0]        auto_sync_th,     // auto updated threshold
  input  wire logic [7:0]        gain_in,          // analog/digital gain
  input  wire logic [9:0]        bottom_level,     // sync tip level
  input  wire logic [9:0]        pedestal_level,   // blank level
  output logic [7:0]             rdata,            // read data
  output logic [7:0]             cb_out,           // output cb
  output logic [7:0]             cr_out,           // output cr
  output logic                   comb_bypass,      // vertical comb off
  output logic                   notch_narrow,     // narrow notch chosen
  output logic                   mono_mode,        // monochrome operation
  output logic                   pal_std_switch,   // standard alternation
  output logic [1:0]             peaking_gain,     // 0 off,1 .5,2 1,3 2
  output logic                   offset_tracking,  // tracking active
  output logic [OFS_W-1:0]       offset_used,      // offset applied
  output logic                   frac_track,       // fractional tracking
  output logic                   hold_decode,      // decode through lost syncs
  output logic                   edge_rising,      // rising sync edge timing
  output logic                   line_lock_check,  // line lock check running
  output logic                   gain_frozen,      // gain locked
  output logic                   double_rate,      // 54 MHz subcarrier stage
  output logic [7:0]             sync_th_used,     // threshold in use
  output logic                   porch_track,      // blank tracked at porch
  output logic                   bottom_line_track,// tip tracked per line
  output logic                   chroma_agc,       // colour agc on
  output logic                   progressive_auto, // progressive autodetect
  output logic                   ckill_auto_off,   // colour-kill autodetect off
  output logic                   panel_out,        // no-signal panel active
  output logic                   panel_ntsc        // panel uses ntsc timing
);

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  logic [7:0] burst_th_q;   // burst difference threshold
  logic [7:0] comb_q;       // comb and notch control
  logic [7:0] palsw_q;      // pal switch and peaking
  logic [7:0] lock_lmt_q;   // lock window and digital gain limit
  logic [7:0] cfg_a_q;      // double rate, gain freeze
  logic [7:0] cfg_b_q;      // stop, hold, edge, settle
  logic [7:0] ofs_ctl_q;    // fixed offset control
  logic [7:0] cti_q;        // porch tracking and chroma_transient_gain
  logic [7:0] lvl_ctl_q;    // level tracking control
  logic [7:0] panel_q;      // panel standard
  logic [7:0] aux_q;        // mono chroma, panel enable, quick switch, ll auto
  logic [7:0] sync_th_q;    // programmed sync threshold
  logic [7:0] ofs_b0_q;     // programmed offset bytes
  logic [7:0] ofs_b1_q;
  logic [4:0] ofs_top_q;

  // register writes; read-only offsets fall through unchanged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      burst_th_q <= vdec_cfg_pkg::RST_BURST_TH;
      comb_q     <= vdec_cfg_pkg::RST_COMB;
      palsw_q    <= vdec_cfg_pkg::RST_PALSW;
      lock_lmt_q <= vdec_cfg_pkg::RST_LOCK_LMT;
      cfg_a_q    <= vdec_cfg_pkg::RST_CFG_A;
      cfg_b_q    <= vdec_cfg_pkg::RST_CFG_B;
      ofs_ctl_q  <= vdec_cfg_pkg::RST_OFS_CTL;
      cti_q      <= vdec_cfg_pkg::RST_CTI;
      lvl_ctl_q  <= vdec_cfg_pkg::RST_LVL_CTL;
      panel_q    <= vdec_cfg_pkg::RST_PANEL;
      aux_q      <= vdec_cfg_pkg::RST_AUX;
    end
    else if (wr)
    begin
      case (addr)
        vdec_cfg_pkg::ADDR_BURST_TH: burst_th_q <= wdata;
        vdec_cfg_pkg::ADDR_COMB:     comb_q     <= wdata;
        vdec_cfg_pkg::ADDR_PALSW:    palsw_q    <= wdata;
        vdec_cfg_pkg::ADDR_LOCK_LMT: lock_lmt_q <= wdata;
        vdec_cfg_pkg::ADDR_CFG_A:    cfg_a_q    <= wdata;
        vdec_cfg_pkg::ADDR_CFG_B:    cfg_b_q    <= wdata;
        vdec_cfg_pkg::ADDR_OFS_CTL:  ofs_ctl_q  <= wdata;
        vdec_cfg_pkg::ADDR_CTI:      cti_q      <= wdata;
        vdec_cfg_pkg::ADDR_LVL_CTL:  lvl_ctl_q  <= wdata;
        vdec_cfg_pkg::ADDR_PANEL:    panel_q    <= wdata;
        vdec_cfg_pkg::ADDR_AUX:      aux_q      <= wdata;
        default: ;
      endcase
    end
  end

  // fixed-offset value and programmed threshold live behind shared offsets;
  // a write there loads the override, a read still shows live status
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_th_q <= vdec_cfg_pkg::RST_SYNC_TH;
      ofs_b0_q  <= 8'h00;
      ofs_b1_q  <= 8'h00;
      ofs_top_q <= 5'h00;
    end
    else if (wr)
    begin
      case (addr)
        vdec_cfg_pkg::ADDR_OFS_B0:  ofs_b0_q  <= wdata;
        vdec_cfg_pkg::ADDR_OFS_B1:  ofs_b1_q  <= wdata;
        vdec_cfg_pkg::ADDR_OFS_TOP: ofs_top_q <= wdata[4:0];
        vdec_cfg_pkg::ADDR_GAIN:    sync_th_q <= wdata;        // threshold shadow
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock offset tracking and lock
  logic [OFS_W-1:0] ofs_q;        // tracked offset
  logic             locked_q;     // offset lock flag
  logic             lock_seen_q;  // first lock reached
  logic [OFS_W-1:0] ofs_abs;
  logic [7:0]       window_ppm;
  logic             in_window;
  logic             track_en;

  always_comb
  begin
    ofs_abs    = ofs_measured[OFS_W-1] ? (~ofs_measured + 1'b1) : ofs_measured;
    window_ppm = 8'(lock_lmt_q[7:4] * vdec_cfg_pkg::PPM_PER_STEP);
    in_window  = (lock_lmt_q[7:4] != 4'h0) && (ofs_abs < OFS_W'(window_ppm));
    if (lock_lmt_q[7:4] == 4'h0)
      track_en = 1'b1;
    else if (cfg_b_q[vdec_cfg_pkg::B_STOP_OPT])
      track_en = !lock_seen_q && !in_window;
    else
      track_en = !in_window;
  end

  // tracked value follows measurement only while tracking
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ofs_q       <= '0;
      locked_q    <= 1'b0;
      lock_seen_q <= 1'b0;
    end
    else
    begin
      if (track_en)
        ofs_q <= ofs_measured;
      locked_q <= in_window;
      if (in_window)
        lock_seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame counting for line-lock settle and gain freeze
  logic [4:0] frames_q;    // saturating frame count since decode start
  logic [4:0] settle_need;

  always_comb
  begin
    case (cfg_b_q[vdec_cfg_pkg::B_SETTLE_LO +: 2])
      2'h0:    settle_need = 5'h00;
      2'h1:    settle_need = vdec_cfg_pkg::FRAMES_8;
      default: settle_need = vdec_cfg_pkg::FRAMES_16;
    endcase
  end

  // restart at decode start; stop at 16 so compare stays cheap
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      frames_q <= 5'h00;
    else if (decode_start)
      frames_q <= 5'h00;
    else if (frame_end && frames_q != vdec_cfg_pkg::FRAMES_16)
      frames_q <= frames_q + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cb_out <= 8'h00; cr_out <= 8'h00;
      comb_bypass <= 1'b0; notch_narrow <= 1'b0; mono_mode <= 1'b0;
      pal_std_switch <= 1'b0; peaking_gain <= 2'h0;
      offset_tracking <= 1'b0; offset_used <= '0; frac_track <= 1'b0;
      hold_decode <= 1'b0; edge_rising <= 1'b0; line_lock_check <= 1'b0;
      gain_frozen <= 1'b0; double_rate <= 1'b0; sync_th_used <= 8'h00;
      porch_track <= 1'b0; bottom_line_track <= 1'b0; chroma_agc <= 1'b0;
      progressive_auto <= 1'b0; ckill_auto_off <= 1'b0;
      panel_out <= 1'b0; panel_ntsc <= 1'b0;
    end
    else
    begin
      // neutral chroma overrides decoded colour
      if (aux_q[vdec_cfg_pkg::B_MONO_CHROMA])
      begin
        cb_out <= vdec_cfg_pkg::NEUTRAL_CHROMA;
        cr_out <= vdec_cfg_pkg::NEUTRAL_CHROMA;
      end
      else
      begin
        cb_out <= cb_in;
        cr_out <= cr_in;
      end
      comb_bypass    <= comb_q[vdec_cfg_pkg::B_VCOMB_DIS];
      notch_narrow   <= comb_q[vdec_cfg_pkg::B_NOTCH_SEL];
      mono_mode      <= comb_q[vdec_cfg_pkg::B_LUMA_FORCE];
      pal_std_switch <= palsw_q[vdec_cfg_pkg::B_PALSW];
      peaking_gain   <= palsw_q[vdec_cfg_pkg::B_SHARP_LO +: 2];
      offset_tracking <= track_en && !ofs_ctl_q[vdec_cfg_pkg::B_FIXED_OFS];
      if (ofs_ctl_q[vdec_cfg_pkg::B_FIXED_OFS])
        offset_used <= OFS_W'({ofs_top_q, ofs_b1_q, ofs_b0_q});
      else
        offset_used <= ofs_q;
      frac_track  <= ofs_ctl_q[vdec_cfg_pkg::B_FRAC_TRACK];
      hold_decode <= cfg_b_q[vdec_cfg_pkg::B_HOLD_OPT];
      edge_rising <= cfg_b_q[vdec_cfg_pkg::B_EDGE_SEL];
      line_lock_check <= aux_q[vdec_cfg_pkg::B_LL_AUTO]
                         && (frames_q >= settle_need);
      gain_frozen <= cfg_a_q[vdec_cfg_pkg::B_GAIN_FREEZE]
                     && (frames_q == vdec_cfg_pkg::FRAMES_16);
      double_rate <= cfg_a_q[vdec_cfg_pkg::B_FORCE_DR]
                     || (cfg_a_q[vdec_cfg_pkg::B_AUTO_DR] && burst_443);
      // threshold choice; keep only matters while quick switching
      if (lvl_ctl_q[vdec_cfg_pkg::B_THR_FIXED] || ofs_ctl_q[vdec_cfg_pkg::B_FIXED_SYNC]
          || !lvl_ctl_q[vdec_cfg_pkg::B_THR_AUTO])
        sync_th_used <= sync_th_q;
      else if (aux_q[vdec_cfg_pkg::B_QUICK_SW] && !lvl_ctl_q[vdec_cfg_pkg::B_THR_KEEP])
        sync_th_used <= sync_th_q;
      else
        sync_th_used <= auto_sync_th;
      porch_track       <= cti_q[vdec_cfg_pkg::B_PORCH_TRK];
      bottom_line_track <= lvl_ctl_q[vdec_cfg_pkg::B_BOTTOM_TRK];
      chroma_agc        <= lvl_ctl_q[vdec_cfg_pkg::B_CHROMA_AGC];
      progressive_auto  <= lvl_ctl_q[vdec_cfg_pkg::B_PROG_AUTO];
      ckill_auto_off    <= lvl_ctl_q[vdec_cfg_pkg::B_CKILL_OFF];
      panel_out  <= aux_q[vdec_cfg_pkg::B_PANEL_EN] && !video_present;
      // pal wins when both or neither standard bit is set
      panel_ntsc <= panel_q[vdec_cfg_pkg::B_NTSC_PANEL]
                    && !panel_q[vdec_cfg_pkg::B_PAL_PANEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the read strobe
  logic [7:0]       rmux;
  logic [23:0]      ofs_ext;

  always_comb
  begin
    ofs_ext = 24'(ofs_q);
    case (addr)
      vdec_cfg_pkg::ADDR_BURST_TH:    rmux = burst_th_q;
      vdec_cfg_pkg::ADDR_COMB:        rmux = comb_q;
      vdec_cfg_pkg::ADDR_PALSW:       rmux = palsw_q;
      vdec_cfg_pkg::ADDR_STD_STS:     rmux = std_flags;
      vdec_cfg_pkg::ADDR_LOCK_STS:    rmux = {locked_q, 6'h00, progressive_in};
      vdec_cfg_pkg::ADDR_LOCK_LMT:    rmux = lock_lmt_q;
      vdec_cfg_pkg::ADDR_CFG_A:       rmux = cfg_a_q;
      vdec_cfg_pkg::ADDR_CFG_B:       rmux = cfg_b_q;
      vdec_cfg_pkg::ADDR_OFS_CTL:     rmux = ofs_ctl_q;
      vdec_cfg_pkg::ADDR_CTI:         rmux = cti_q;
      vdec_cfg_pkg::ADDR_LVL_CTL:     rmux = lvl_ctl_q;
      vdec_cfg_pkg::ADDR_GAIN:        rmux = gain_in;
      vdec_cfg_pkg::ADDR_BOTTOM_LO:   rmux = bottom_level[7:0];
      vdec_cfg_pkg::ADDR_PEDESTAL_LO: rmux = pedestal_level[7:0];
      vdec_cfg_pkg::ADDR_OFS_B0:      rmux = ofs_ext[7:0];
      vdec_cfg_pkg::ADDR_OFS_B1:      rmux = ofs_ext[15:8];
      vdec_cfg_pkg::ADDR_OFS_TOP:     rmux = {3'h0, ofs_ext[20:16]};
      vdec_cfg_pkg::ADDR_LVL_HI:      rmux = {pedestal_level[9:8], 4'h0,
                                              bottom_level[9:8]};
      vdec_cfg_pkg::ADDR_PANEL:       rmux = panel_q;
      vdec_cfg_pkg::ADDR_AUX:         rmux = aux_q;
      default:                        rmux = 8'h00;
    endcase
  end

  // unmapped address or idle cycle reads zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rmux;
    else
      rdata <= 8'h00;
  end

endmodule : vdec_tracking_cfg

// ---- testbench/video_source_model.sv ----
// behavioural source of digitised composite video status for the bank
// assumes the bench steers presence and burst and asks for frame pulses
`timescale 1ns/1ps

module video_source_model (
  input  wire logic        clk,            // decoder clock
  input  wire logic        present,        // video on the input
  input  wire logic        sub_443,        // 4.43 burst seen
  output logic             frame_end,      // frame pulse
  output logic             decode_start,   // decode start pulse
  output logic             video_present,  // signal detected
  output logic             burst_443,      // subcarrier flag
  output logic [7:0]       std_flags,      // standard flags
  output logic             progressive_in, // progressive seen
  output logic [20:0]      ofs_measured,   // measured offset
  output logic [7:0]       auto_sync_th,   // tracked threshold
  output logic [7:0]       gain_in,        // gain levels
  output logic [9:0]       bottom_level,   // tip level
  output logic [9:0]       pedestal_level, // blank level
  output logic [7:0]       cb_in,          // chroma blue
  output logic [7:0]       cr_in           // chroma red
);
  // fixed levels keep expectations simple; pulses come from tasks
  assign video_present  = present;
  assign burst_443      = sub_443;
  assign std_flags      = 8'h24;
  assign progressive_in = 1'b1;
  assign ofs_measured   = 21'h1ABCDE;
  assign auto_sync_th   = 8'h47;
  assign gain_in        = 8'h93;
  assign bottom_level   = 10'h2A5;
  assign pedestal_level = 10'h15A;
  assign cb_in          = 8'h3C;
  assign cr_in          = 8'hC3;
  initial frame_end = 1'b0;
  initial decode_start = 1'b0;

  // one-cycle frame pulses with a gap between them
  task automatic frames(input int n);
    repeat (n)
    begin
      @(posedge clk);
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
    end
  endtask : frames

  // one-cycle start of decoding
  task automatic start;
    @(posedge clk);
    decode_start <= 1'b1;
    @(posedge clk);
    decode_start <= 1'b0;
  endtask : start
endmodule : video_source_model

// ---- testbench/vdec_tracking_cfg_props.sv ----
// checker of port relations of the tracking configuration bank
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps

module vdec_cfg_props (
  input wire logic       clk, rst_n, wr, rd, video_present, comb_bypass, notch_narrow,
  input wire logic       mono_mode, pal_std_switch, double_rate, hold_decode, edge_rising,
  input wire logic       porch_track, frac_track, chroma_agc, progressive_auto, panel_out,
  input wire logic       ckill_auto_off, bottom_line_track,
  input wire logic [7:0] addr, wdata, std_flags, rdata,
  input wire logic [1:0] peaking_gain
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  AST_COMB: assert property (wr && addr == 8'h09 |-> ##2 comb_bypass == $past(wdata[0], 2)
    && notch_narrow == $past(wdata[1], 2) && mono_mode == $past(wdata[4], 2))
    else $error("comb fields not applied");
  AST_SHARP: assert property (wr && addr == 8'h0C |-> ##2 peaking_gain == $past(wdata[7:6], 2)
    && pal_std_switch == $past(wdata[0], 2)) else $error("sharpness fields not applied");
  AST_EDGE: assert property (wr && addr == 8'h14 |-> ##2 edge_rising == $past(wdata[2], 2)
    && hold_decode == $past(wdata[1], 2)) else $error("edge or hold option not applied");
  AST_PORCH: assert property (wr && addr == 8'h17 |-> ##2 porch_track == $past(wdata[7], 2))
    else $error("porch tracking not applied");
  AST_FRAC: assert property (wr && addr == 8'h15 |-> ##2 frac_track == $past(wdata[2], 2))
    else $error("fraction tracking not applied");
  AST_LEVEL: assert property (wr && addr == 8'h18 |-> ##2 chroma_agc == $past(wdata[3], 2)
    && progressive_auto == $past(wdata[4], 2) && ckill_auto_off == $past(wdata[6], 2)
    && bottom_line_track == $past(wdata[1], 2)) else $error("level options not applied");
  AST_FORCE_RATE: assert property (wr && addr == 8'h13 && wdata[7] |-> ##2 double_rate)
    else $error("forced double rate missing");
  AST_STD_READ: assert property (rd && addr == 8'h10 |=> rdata == $past(std_flags))
    else $error("standard flags read wrong");
  AST_READ_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  AST_PANEL_OFF: assert property ($past(video_present) && $past(video_present, 2) |-> !panel_out)
    else $error("panel shown with video present");
endmodule : vdec_cfg_props

bind vdec_tracking_cfg vdec_cfg_props u_props (.clk, .rst_n, .wr, .rd, .video_present,
  .comb_bypass, .notch_narrow, .mono_mode, .pal_std_switch, .double_rate, .hold_decode,
  .edge_rising, .porch_track, .frac_track, .chroma_agc, .progressive_auto, .panel_out,
  .ckill_auto_off, .bottom_line_track, .addr, .wdata, .std_flags, .rdata, .peaking_gain);

// ---- testbench/test_video_decoder_tracking_config.sv ----
// self-checking bench of the tracking configuration bank
// assumes the source model on the video side and the register port here
`timescale 1ns/1ps

module test_video_decoder_tracking_config;
  logic        clk, rst_n, wr, rd, present, sub_443, frame_end, decode_start, video_present;
  logic        burst_443, progressive_in, comb_bypass, notch_narrow, mono_mode, pal_std_switch;
  logic        offset_tracking, frac_track, hold_decode, edge_rising, line_lock_check;
  logic        gain_frozen, double_rate, porch_track, bottom_line_track, chroma_agc;
  logic        progressive_auto, ckill_auto_off, panel_out, panel_ntsc;
  logic [7:0]  addr, wdata, rdata, cb_in, cr_in, cb_out, cr_out, std_flags, auto_sync_th;
  logic [7:0]  gain_in, sync_th_used, v;
  logic [9:0]  bottom_level, pedestal_level;
  logic [20:0] ofs_measured, offset_used;
  logic [1:0]  peaking_gain;
  int          n_fail, checks_done;
  logic [7:0]  pat[4] = '{8'h01, 8'h02, 8'h10, 8'h00};

  vdec_tracking_cfg DUT (.*);
  video_source_model model (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one write cycle, then wait until it shows at the outputs
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr_reg

  // one read cycle; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a, v);
    chk(v, exp);
  endtask : rchk

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, wr, rd, addr, wdata, sub_443, n_fail, checks_done} = '0;
    present = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h08, 8'h20);
    rchk(8'h17, 8'h0A);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h09, pat[i]);
      chk({comb_bypass, notch_narrow, mono_mode}, {pat[i][0], pat[i][1], pat[i][4]});
    end
    for (int g = 0; g < 4; g++)
    begin
      wr_reg(8'h0C, {g[1:0], 5'h00, g[0]});
      chk({peaking_gain, pal_std_switch}, {g[1:0], g[0]});
    end
    // status writes must not stick
    wr_reg(8'h10, 8'hFF);
    rchk(8'h10, 8'h24);
    wr_reg(8'h11, 8'h00);
    rd_reg(8'h11, v);
    chk(v[0], 1'b1);
    rchk(8'h23, 8'hDE);
    rchk(8'h24, 8'hBC);
    rchk(8'h25, 8'h1A);
    // fixed offset override, readback stays live
    wr_reg(8'h23, 8'h11);
    wr_reg(8'h24, 8'h22);
    wr_reg(8'h25, 8'h13);
    wr_reg(8'h15, 8'h01);
    chk({offset_used, frac_track}, {21'h132211, 1'b0});
    rchk(8'h23, 8'hDE);
    // threshold source selection
    wr_reg(8'h20, 8'h55);
    wr_reg(8'h15, 8'h06);
    chk({sync_th_used, frac_track}, {8'h55, 1'b1});
    wr_reg(8'h15, 8'h00);
    wr_reg(8'h18, 8'h01);
    chk(sync_th_used, 8'h47);
    wr_reg(8'h18, 8'h5A);
    chk({sync_th_used, bottom_line_track, chroma_agc, progressive_auto, ckill_auto_off},
        {8'h55, 4'hF});
    wr_reg(8'h3C, 8'h80);
    chk({cb_out, cr_out}, 16'h8080);
    wr_reg(8'h3C, 8'h00);
    chk({cb_out, cr_out}, 16'h3CC3);
    // double rate by detection, then by force
    sub_443 <= 1'b1;
    wr_reg(8'h13, 8'h40);
    chk(double_rate, 1'b1);
    sub_443 <= 1'b0;
    wr_reg(8'h13, 8'h40);
    chk(double_rate, 1'b0);
    wr_reg(8'h13, 8'h80);
    chk(double_rate, 1'b1);
    // gain freezes on the sixteenth frame, not the fifteenth
    wr_reg(8'h13, 8'h20);
    model.start();
    model.frames(15);
    repeat (3) @(posedge clk);
    chk(gain_frozen, 1'b0);
    model.frames(1);
    repeat (3) @(posedge clk);
    chk(gain_frozen, 1'b1);
    wr_reg(8'h3C, 8'h01);
    chk({line_lock_check, offset_tracking}, 2'b11);
    wr_reg(8'h12, 8'h0F);
    chk(offset_tracking, 1'b1);
    wr_reg(8'h14, 8'h06);
    chk({edge_rising, hold_decode}, 2'b11);
    wr_reg(8'h17, 8'h8A);
    chk(porch_track, 1'b1);
    // no-signal panel and its standard
    wr_reg(8'h29, 8'h01);
    wr_reg(8'h3C, 8'h08);
    present <= 1'b0;
    repeat (3) @(posedge clk);
    chk({panel_out, panel_ntsc}, 2'b11);
    wr_reg(8'h29, 8'h00);
    chk({panel_out, panel_ntsc}, 2'b10);
    present <= 1'b1;
    repeat (3) @(posedge clk);
    chk(panel_out, 1'b0);
    rchk(8'h3F, 8'h00);
    results();
  end
endmodule : test_video_decoder_tracking_config
